/* File: verilog/filt_range_pkg.sv */
`default_nettype none
package filt_range_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] FILTER_ADDR = 16'h9ca0;
    localparam logic [15:0] RANGE_ADDR = 16'h9ca1;
    localparam logic [15:0] FILTER_RESET = 16'h0000;
    localparam logic [15:0] RANGE_RESET = 16'h0000;
    localparam int SMALL_LSB = 0;
    localparam int LARGE_LSB = 4;
    // ****************************************
    // protocol codes
    // ****************************************
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE_ONE = 8'h06;
    localparam logic [7:0] FN_WRITE_MANY = 8'h10;
    localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0] EXC_NAK = 8'h07;
    localparam logic [7:0] MAX_NV_VALUES = 8'h04;

    typedef enum logic [2:0] {
        SPAN_OFF, SPAN_10V, SPAN_5V, SPAN_1V, SPAN_100MV, SPAN_50MV, SPAN_BAD
    } span_t;

    // one decoded register access from the frame parser
    typedef struct packed {
        logic       valid;
        logic [7:0] func;
        logic [15:0] addr;
        logic [7:0] index;
        logic [7:0] count;
        logic [15:0] data;
    } req_t;

    typedef struct packed {
        logic       valid;
        logic       exc;
        logic [7:0] code;
        logic [15:0] data;
    } rsp_t;
endpackage
`default_nettype wire

/* File: verilog/filter_decode.sv */
`default_nettype none
module filter_decode (
    // filter register
    input wire logic [15:0] i_filter,
    // decoded constants, in half-second units, and the reserved large code flag
    output logic [7:0] o_small_halfsec,
    output logic [7:0] o_large_halfsec,
    output logic o_large_reserved
);
    function automatic logic [7:0] code_to_halfsec(input logic [3:0] c);
        // 0 -> 0 s, then doubling from 0.5 s
        code_to_halfsec = (c == 4'h0) ? 8'h00 : 8'(8'h01 << (c - 4'h1));
    endfunction
    wire logic [3:0] small_code = i_filter[filt_range_pkg::SMALL_LSB +: 4];
    wire logic [3:0] large_code = i_filter[filt_range_pkg::LARGE_LSB +: 4];
    assign o_small_halfsec = (small_code < 4'h8) ? code_to_halfsec(small_code) : 8'h00;
    assign o_large_reserved = large_code > 4'h3;
    assign o_large_halfsec = o_large_reserved ? 8'h00 : code_to_halfsec(large_code);
endmodule // filter_decode
`default_nettype wire

/* File: verilog/input_filter_range_regs.sv */
`default_nettype none
module input_filter_range_regs (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // request from frame parser, same clock
    input wire filt_range_pkg::req_t i_req,
    // write enable of the non-volatile store, from a pin
    input wire logic i_nv_wr_en,
    // answer to frame builder
    output filt_range_pkg::rsp_t o_rsp,
    // configuration out
    output logic [15:0] o_filter,
    output logic [15:0] o_range,
    output filt_range_pkg::span_t o_span,
    output logic [7:0] o_small_halfsec,
    output logic [7:0] o_large_halfsec,
    output logic o_large_reserved
);
    // ****************************************
    // pin synchroniser
    // ****************************************
    // the store enable comes from a pin, so nothing reads it before the second flop
    logic nv_meta_q;
    logic nv_en_q;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            nv_meta_q <= 1'b0;
            nv_en_q <= 1'b0;
        end else begin
            nv_meta_q <= i_nv_wr_en;
            nv_en_q <= nv_meta_q;
        end
    end

    // ****************************************
    // request decode
    // ****************************************
    logic [15:0] filter_q;
    logic [15:0] range_q;
    filt_range_pkg::rsp_t rsp_q;
    filt_range_pkg::rsp_t rsp_d;

    function automatic filt_range_pkg::span_t span_of(input logic [15:0] r);
        case (r[7:0])
            8'h00: span_of = filt_range_pkg::SPAN_OFF;
            8'h01: span_of = filt_range_pkg::SPAN_10V;
            8'h02: span_of = filt_range_pkg::SPAN_5V;
            8'h03: span_of = filt_range_pkg::SPAN_1V;
            8'h04: span_of = filt_range_pkg::SPAN_100MV;
            8'h05: span_of = filt_range_pkg::SPAN_50MV;
            default: span_of = filt_range_pkg::SPAN_BAD;
        endcase
    endfunction

    wire logic is_read = i_req.func == filt_range_pkg::FN_READ;
    wire logic is_one = i_req.func == filt_range_pkg::FN_WRITE_ONE;
    wire logic is_many = i_req.func == filt_range_pkg::FN_WRITE_MANY;
    wire logic is_write = is_one | is_many;
    wire logic hit_filter = i_req.addr == filt_range_pkg::FILTER_ADDR;
    wire logic hit_range = i_req.addr == filt_range_pkg::RANGE_ADDR;
    wire logic too_many = is_many && (i_req.count > filt_range_pkg::MAX_NV_VALUES);
    wire logic nv_refused = is_write && hit_range && !nv_en_q;
    wire logic wr_filter = i_req.valid && is_write && hit_filter && !too_many;
    wire logic wr_range = i_req.valid && is_write && hit_range && !too_many && nv_en_q;

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = i_req.valid;
        rsp_d.code = i_req.func;
        if (!(is_read || is_write)) begin
            rsp_d.exc = 1'b1;
            rsp_d.code = filt_range_pkg::EXC_ILLEGAL_FN;
        end else if (!(hit_filter || hit_range)) begin
            rsp_d.exc = 1'b1;
            rsp_d.code = filt_range_pkg::EXC_ILLEGAL_ADDR;
        end else if (too_many) begin
            rsp_d.exc = 1'b1;
            rsp_d.code = filt_range_pkg::EXC_ILLEGAL_VALUE;
        end else if (nv_refused) begin
            rsp_d.exc = 1'b1;
            rsp_d.code = filt_range_pkg::EXC_NAK;
        end else if (is_read) begin
            rsp_d.data = hit_filter ? filter_q : range_q;
        end else begin
            rsp_d.data = i_req.data;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            filter_q <= filt_range_pkg::FILTER_RESET;
            range_q <= filt_range_pkg::RANGE_RESET;
            rsp_q <= '0;
        end else begin
            if (wr_filter) begin
                filter_q <= i_req.data;
            end
            if (wr_range) begin
                range_q <= i_req.data;
            end
            rsp_q <= rsp_d;
        end
    end

    assign o_rsp = rsp_q;
    assign o_filter = filter_q;
    assign o_range = range_q;
    assign o_span = span_of(range_q);

    filter_decode u_filter_decode (
        .i_filter(filter_q),
        .o_small_halfsec(o_small_halfsec),
        .o_large_halfsec(o_large_halfsec),
        .o_large_reserved(o_large_reserved)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // ****************************************
    // range register protection
    // ****************************************
    // locked store holds
    a_range_protect: assert property (!nv_en_q |=> $stable(range_q))
        else $error("range changed while store locked");
    a_nak_no_write: assert property (i_req.valid && nv_refused |=> $stable(range_q))
        else $error("refused range write changed register");
    a_range_write: assert property (wr_range |=> range_q == $past(i_req.data))
        else $error("range write lost");
    a_nak_code: assert property (i_req.valid && nv_refused && !too_many && is_write
        |=> o_rsp.exc && o_rsp.code == 8'h07)
        else $error("locked range write not answered with 07h");
    a_preset_limit: assert property (i_req.valid && too_many |=> $stable(range_q) && $stable(filter_q) && o_rsp.exc)
        else $error("oversize preset accepted");

    // ****************************************
    // filter register and decode
    // ****************************************
    // filter write lands
    a_filter_write: assert property (wr_filter |=> filter_q == $past(i_req.data))
        else $error("filter write lost");
    // unwritten filter register keeps its value
    a_filter_hold: assert property (!wr_filter |=> $stable(filter_q))
        else $error("filter changed without a write");
    a_small_decode: assert property (filter_q[3:0] == 4'h7 |-> o_small_halfsec == 8'h40)
        else $error("small constant 32 s wrong");
    a_small_zero: assert property (filter_q[3:0] == 4'h0 |-> o_small_halfsec == 8'h00)
        else $error("small constant zero wrong");
    a_large_decode: assert property (filter_q[7:4] == 4'h3 |-> o_large_halfsec == 8'h04 && !o_large_reserved)
        else $error("large constant 2 s wrong");
    a_large_half: assert property (filter_q[7:4] == 4'h1 |-> o_large_halfsec == 8'h01)
        else $error("large constant 0.5 s wrong");
    a_large_rsvd: assert property (filter_q[7:4] > 4'h3 |-> o_large_reserved && o_large_halfsec == 8'h00)
        else $error("reserved large code not flagged");

    // ****************************************
    // range decode and answers
    // ****************************************
    // smallest span
    a_span_decode: assert property (range_q[7:0] == 8'h05 |-> o_span == filt_range_pkg::SPAN_50MV)
        else $error("range decode wrong");
    a_span_off: assert property (range_q[7:0] == 8'h00 |-> o_span == filt_range_pkg::SPAN_OFF)
        else $error("disabled channel decode wrong");
    a_span_bad: assert property (range_q[7:0] > 8'h05 |-> o_span == filt_range_pkg::SPAN_BAD)
        else $error("undefined range code not flagged");
    // every request answered next cycle
    a_resp_follow: assert property (i_req.valid |=> o_rsp.valid)
        else $error("request not answered");
    // no answer without a request
    a_resp_single: assert property (!i_req.valid |=> !o_rsp.valid)
        else $error("answer without request");
    // unknown function refused first
    a_fn_refuse: assert property (i_req.valid && !(is_read || is_write)
        |=> o_rsp.exc && o_rsp.code == filt_range_pkg::EXC_ILLEGAL_FN)
        else $error("unknown function not refused");
    // address outside the slice refused
    a_addr_refuse: assert property (i_req.valid && (is_read || is_write) && !(hit_filter || hit_range)
        |=> o_rsp.exc && o_rsp.code == filt_range_pkg::EXC_ILLEGAL_ADDR)
        else $error("unknown address not refused");
    // range read returns the stored word
    a_read_data: assert property (i_req.valid && is_read && hit_range
        |=> !o_rsp.exc && o_rsp.data == $past(range_q))
        else $error("range read data wrong");

    // main scenarios
    c_nak: cover property (i_req.valid && nv_refused ##1 o_rsp.exc);
    c_range_wr: cover property (wr_range);
    c_filter_rd: cover property (i_req.valid && is_read && hit_filter);
    c_preset_over: cover property (i_req.valid && too_many);
    c_filter_wr: cover property (wr_filter && is_many);
endmodule // input_filter_range_regs
`default_nettype wire

/* File: sim/modbus_host_model.sv */
`default_nettype none
module modbus_host_model (
    // clock
    input wire logic i_clk_sys,
    // request out, answer in
    output filt_range_pkg::req_t o_req,
    input wire filt_range_pkg::rsp_t i_rsp
);
    timeunit 1ns;
    timeprecision 100ps;
    initial o_req = '0;
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [7:0] n, input logic [15:0] d,
                        input logic over, output filt_range_pkg::rsp_t r);
        if (!over && n > filt_range_pkg::MAX_NV_VALUES) n = filt_range_pkg::MAX_NV_VALUES;
        @(posedge i_clk_sys);
        #1 o_req = '{1'b1, f, a, 8'h00, n, d};
        @(posedge i_clk_sys);
        #1 r = i_rsp;
        // released fields turn to garbage so no stale word passes
        o_req = '{1'b0, ~f, ~a, 8'hff, ~n, ~d};
    endtask
endmodule // modbus_host_model
`default_nettype wire

/* File: sim/test_input_filter_range_regs.sv */
`default_nettype none
module test_input_filter_range_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic nv = 1'b0;
    filt_range_pkg::req_t req;
    filt_range_pkg::rsp_t rsp, r;
    logic [15:0] flt, rng, d;
    filt_range_pkg::span_t span;
    logic [7:0] sml, lrg, f;
    logic rsv;
    int n_mismatch = 0;
    int num_checks = 0;
    integer seed = 17929;
    always #2 i_clk_sys = ~i_clk_sys;
    modbus_host_model modbus_host_model_inst (.i_clk_sys(i_clk_sys), .o_req(req), .i_rsp(rsp));
    input_filter_range_regs input_filter_range_regs_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req),
        .i_nv_wr_en(nv), .o_rsp(rsp), .o_filter(flt), .o_range(rng), .o_span(span),
        .o_small_halfsec(sml), .o_large_halfsec(lrg), .o_large_reserved(rsv));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] halfsec(input logic [3:0] c);
        return (c == 0) ? 8'h00 : 8'h01 << (c - 1);
    endfunction
    // exception answers carry no data worth comparing
    task automatic acc(input logic [7:0] fn, input logic [15:0] a, input logic [7:0] n, input logic [15:0] dd,
                       input logic [7:0] code, input logic [15:0] ed);
        modbus_host_model_inst.send(fn, a, n, dd, n > 4, r);
        check({r.valid, r.exc, r.code, r.exc ? 16'h0 : r.data}, {1'b1, code != fn, code, code != fn ? 16'h0 : ed});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000 n_mismatch++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        check({flt, rng, 5'h0, span}, 40'h0);
        for (int i = 0; i < 24; i++) begin
            d = (i == 0) ? 16'h0037 : (i == 1) ? 16'h0040 : 16'($random(seed)) & 16'h00f7;
            f = i[0] ? 8'h10 : 8'h06;
            acc(f, 16'h9ca0, 8'h04, d, f, d);
            check({flt, sml}, {d, halfsec(d[3:0])});
            check({rsv, lrg}, {d[7:4] > 3, d[7:4] > 3 ? 8'h0 : halfsec(d[7:4])});
        end
        acc(8'h06, 16'h9ca1, 8'h01, 16'h0003, 8'h07, 16'h0);
        check(rng, 16'h0000);
        nv = 1'b1;
        repeat (3) @(posedge i_clk_sys);
        for (int c = 0; c < 8; c++) begin
            acc(8'h06, 16'h9ca1, 8'h01, 16'(c), 8'h06, 16'(c));
            check(span, c < 6 ? c : 6);
        end
        acc(8'h10, 16'h9ca1, 8'h05, 16'h0002, 8'h03, 16'h0);
        acc(8'h10, 16'h9ca1, 8'h04, 16'h0002, 8'h10, 16'h0002);
        acc(8'h03, 16'h9ca0, 8'h01, 16'h0, 8'h03, d);
        acc(8'h03, 16'h9ca1, 8'h01, 16'h0, 8'h03, 16'h0002);
        acc(8'h2b, 16'h9ca0, 8'h01, 16'h0, 8'h01, 16'h0);
        acc(8'h06, 16'h9ca2, 8'h01, 16'h0, 8'h02, 16'h0);
        nv = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        acc(8'h10, 16'h9ca1, 8'h02, 16'h0001, 8'h07, 16'h0);
        check(rng, 16'h0002);
        end_sim;
    end
endmodule // test_input_filter_range_regs
`default_nettype wire
